/* logic/tpiod_pkg.sv */
// Package: constants for the three-port I/O address decoder
package tpiod_pkg;

  // ----------------------------------------------------------------
  // Configuration offsets (byte addresses, dword aligned access)
  // ----------------------------------------------------------------
  localparam logic [7:0] IO_WINDOW_BASE_LOW_OFS   = 8'h1c;
  localparam logic [7:0] IO_WINDOW_LIMIT_LOW_OFS  = 8'h1d;
  localparam logic [7:0] IO_WINDOW_BASE_HIGH_OFS  = 8'h30;
  localparam logic [7:0] IO_WINDOW_LIMIT_HIGH_OFS = 8'h32;
  localparam logic [5:0] DWORD_LOW_IDX            = 6'h07;
  localparam logic [5:0] DWORD_HIGH_IDX           = 6'h0c;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int         NIB_MSB         = 7;
  localparam int         NIB_LSB         = 4;
  localparam logic [3:0] ADDR32_CAP      = 4'h1;
  localparam logic [3:0] BASE_NIB_RST    = 4'h0;
  localparam logic [3:0] LIMIT_NIB_RST   = 4'h0;
  localparam logic [15:0] BASE_HIGH_RST  = 16'h0000;
  localparam logic [15:0] LIMIT_HIGH_RST = 16'h0000;
  localparam logic [11:0] BASE_FILL      = 12'h000;
  localparam logic [11:0] LIMIT_FILL     = 12'hfff;

  // ----------------------------------------------------------------
  // ISA aliasing: first 64KB, 1KB blocks, low 256 bytes pass
  // ----------------------------------------------------------------
  localparam logic [15:0] ISA_REGION_HIGH = 16'h0000;
  localparam int          ISA_SEL_MSB     = 9;
  localparam int          ISA_SEL_LSB     = 8;
  localparam logic [1:0]  ISA_LOW_QUARTER = 2'h0;

  // ----------------------------------------------------------------
  // Transaction origin and destination codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TPIOD_FROM_PRIMARY = 2'h0,
    TPIOD_FROM_SEC_ONE = 2'h1,
    TPIOD_FROM_SEC_TWO = 2'h2
  } tpiod_origin_t;

  localparam logic [2:0] DEST_NONE      = 3'h0;
  localparam logic [2:0] DEST_PRIMARY   = 3'h1;
  localparam logic [2:0] DEST_SEC_ONE   = 3'h2;
  localparam logic [2:0] DEST_SEC_TWO   = 3'h4;

endpackage

/* logic/tpiod_window_match.sv */
// Window comparison and ISA aliasing for one secondary port
`timescale 1ns/1ps

module tpiod_window_match
  import tpiod_pkg::*;
#(
  parameter int ADDR_W = 32
)
(
  input  wire logic [15:0]       base_high,
  input  wire logic [3:0]        base_nib,
  input  wire logic [15:0]       limit_high,
  input  wire logic [3:0]        limit_nib,
  input  wire logic              isa_enable,
  input  wire logic [ADDR_W-1:0] addr,
  output logic                   in_window,
  output logic                   claim
);

  logic [31:0] base_full;
  logic [31:0] limit_full;
  logic        isa_hole;

  initial
  begin
    if (ADDR_W != 32)
      $error("tpiod_window_match: only 32-bit I/O addresses are served");
  end

  always_comb
  begin
    base_full  = {base_high, base_nib, BASE_FILL};
    limit_full = {limit_high, limit_nib, LIMIT_FILL};
    in_window  = (addr >= base_full) && (addr <= limit_full);
    isa_hole   = isa_enable && (addr[31:16] == ISA_REGION_HIGH)
                 && (addr[ISA_SEL_MSB:ISA_SEL_LSB] != ISA_LOW_QUARTER);
    claim      = in_window && !isa_hole;
  end

endmodule

/* logic/tpiod_decoder.sv */
// I/O address decode, routing and window registers of a three-port bridge
`timescale 1ns/1ps

// Operation
// - Primary transactions in downstream ranges go down; other secondary ones go up.
// - Addresses pass unchanged; secondary I/O not claimed downstream goes upstream.
// - Port one initiator, hit in port two window only, routes to port two.
// - Port two initiator, hit in port one window only, routes to port one.
// - Primary I/O is ignored unless the I/O enable bit is set.
// - Secondary I/O and memory are ignored while master enable is clear.
// - Each secondary port has its own 32-bit base and limit window.
// - Inside a port window goes down; outside goes up from secondary.
// - Base above limit disables the window: nothing down, everything up.
// - Window decoding uses 4KB granularity and 4KB-aligned ends.
// - Base low byte: upper nibble is bits 15:12, lower nibble reads 1h.
// - Limit low byte: upper nibble is bits 15:12, lower reads 1h, low bits FFFh.
// - Register at 30h holds base address bits 31:16, fully writable.
// - Register at 32h holds limit address bits 31:16, fully writable.
// - Bus or chip reset sets base 0000_0000h and limit 0000_0FFFh.
// - ISA enable only affects in-window addresses below 64KB.
// - With ISA enable, only the low 256 bytes of each 1KB go down.
// - With ISA enable, upper 768 bytes below 64KB go upstream if master enabled.
// - At or above 64KB the window alone decides, whatever ISA enable says.
// - Other secondary I/O goes upstream when outside the window or in an ISA hole of it.
module tpiod_decoder
  import tpiod_pkg::*;
#(
  parameter int ADDR_W = 32,
  parameter int NUM_SEC = 2
)
(
  input  wire logic                  ref_clk,
  input  wire logic                  reset_n,
  input  wire logic                  prim_bus_reset,
  input  wire logic [NUM_SEC-1:0]    io_enable,
  input  wire logic [NUM_SEC-1:0]    master_enable,
  input  wire logic [NUM_SEC-1:0]    isa_enable,
  input  wire logic                  cfg_write,
  input  wire logic                  cfg_read,
  input  wire logic                  cfg_port,
  input  wire logic [7:0]            cfg_addr,
  input  wire logic [3:0]            cfg_byte_en,
  input  wire logic [31:0]           cfg_wdata,
  output logic [31:0]                cfg_rdata,
  output logic                       cfg_rdata_valid,
  input  wire logic                  txn_valid,
  input  wire tpiod_pkg::tpiod_origin_t txn_origin,
  input  wire logic                  txn_is_io,
  input  wire logic [ADDR_W-1:0]     txn_addr,
  output logic                       route_valid,
  output logic [2:0]                 route_dest,
  output logic                       route_ignored,
  output logic [ADDR_W-1:0]          route_addr
);

  initial
  begin
    if (ADDR_W != 32)
      $error("tpiod_decoder: only 32-bit I/O addresses are served");
    if (NUM_SEC != 2)
      $error("tpiod_decoder: exactly two secondary ports are served");
    if (IO_WINDOW_BASE_LOW_OFS[7:2] != DWORD_LOW_IDX || IO_WINDOW_LIMIT_LOW_OFS[7:2] != DWORD_LOW_IDX)
      $error("tpiod_decoder: low window fields must share one dword");
    if (IO_WINDOW_BASE_HIGH_OFS[7:2] != DWORD_HIGH_IDX || IO_WINDOW_LIMIT_HIGH_OFS[7:2] != DWORD_HIGH_IDX)
      $error("tpiod_decoder: high window fields must share one dword");
    if (IO_WINDOW_BASE_LOW_OFS[1:0] != 2'h0 || IO_WINDOW_LIMIT_LOW_OFS[1:0] != 2'h1)
      $error("tpiod_decoder: low window fields sit in byte lanes 0 and 1");
    if (IO_WINDOW_BASE_HIGH_OFS[1:0] != 2'h0 || IO_WINDOW_LIMIT_HIGH_OFS[1:0] != 2'h2)
      $error("tpiod_decoder: high window fields sit in half-words 0 and 1");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] merge_byte(input logic [7:0] old_val, input logic [7:0] new_val,
                                            input logic enable);
    merge_byte = enable ? new_val : old_val;
  endfunction

  function automatic logic [15:0] merge_half(input logic [15:0] old_val, input logic [15:0] new_val,
                                             input logic [1:0] enable);
    merge_half = {merge_byte(old_val[15:8], new_val[15:8], enable[1]),
                  merge_byte(old_val[7:0], new_val[7:0], enable[0])};
  endfunction

  // ----------------------------------------------------------------
  // Window registers, one set per secondary port
  // ----------------------------------------------------------------
  logic [3:0]  io_window_base_low   [NUM_SEC];
  logic [3:0]  io_window_limit_low  [NUM_SEC];
  logic [15:0] io_window_base_high  [NUM_SEC];
  logic [15:0] io_window_limit_high [NUM_SEC];
  logic [3:0]  next_io_window_base_low   [NUM_SEC];
  logic [3:0]  next_io_window_limit_low  [NUM_SEC];
  logic [15:0] next_io_window_base_high  [NUM_SEC];
  logic [15:0] next_io_window_limit_high [NUM_SEC];
  logic [5:0]  cfg_dword;
  logic [7:0]  base_byte;
  logic [7:0]  limit_byte;

  assign cfg_dword = cfg_addr[7:2];

  // Only the writable nibbles of the low bytes are stored; the 1h capability
  // nibble is put back on read and cannot be overwritten.
  // A bus reset in the same cycle as a write wins and the write is lost.
  always_comb
  begin
    base_byte  = '0;
    limit_byte = '0;
    for (int p = 0; p < NUM_SEC; p++)
    begin
      next_io_window_base_low[p]   = io_window_base_low[p];
      next_io_window_limit_low[p]  = io_window_limit_low[p];
      next_io_window_base_high[p]  = io_window_base_high[p];
      next_io_window_limit_high[p] = io_window_limit_high[p];
      if (prim_bus_reset)
      begin
        next_io_window_base_low[p]   = BASE_NIB_RST;
        next_io_window_limit_low[p]  = LIMIT_NIB_RST;
        next_io_window_base_high[p]  = BASE_HIGH_RST;
        next_io_window_limit_high[p] = LIMIT_HIGH_RST;
      end
      else if (cfg_write && (cfg_port == p[0]))
      begin
        if (cfg_dword == DWORD_LOW_IDX)
        begin
          base_byte  = merge_byte({io_window_base_low[p], ADDR32_CAP}, cfg_wdata[7:0], cfg_byte_en[0]);
          limit_byte = merge_byte({io_window_limit_low[p], ADDR32_CAP}, cfg_wdata[15:8], cfg_byte_en[1]);
          next_io_window_base_low[p]  = base_byte[NIB_MSB:NIB_LSB];
          next_io_window_limit_low[p] = limit_byte[NIB_MSB:NIB_LSB];
        end
        if (cfg_dword == DWORD_HIGH_IDX)
        begin
          next_io_window_base_high[p]  = merge_half(io_window_base_high[p], cfg_wdata[15:0],
                                                    cfg_byte_en[1:0]);
          next_io_window_limit_high[p] = merge_half(io_window_limit_high[p], cfg_wdata[31:16],
                                                    cfg_byte_en[3:2]);
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int p = 0; p < NUM_SEC; p++)
      begin
        io_window_base_low[p]   <= BASE_NIB_RST;
        io_window_limit_low[p]  <= LIMIT_NIB_RST;
        io_window_base_high[p]  <= BASE_HIGH_RST;
        io_window_limit_high[p] <= LIMIT_HIGH_RST;
      end
    end
    else
    begin
      for (int p = 0; p < NUM_SEC; p++)
      begin
        io_window_base_low[p]   <= next_io_window_base_low[p];
        io_window_limit_low[p]  <= next_io_window_limit_low[p];
        io_window_base_high[p]  <= next_io_window_base_high[p];
        io_window_limit_high[p] <= next_io_window_limit_high[p];
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration read-back
  // ----------------------------------------------------------------
  logic [31:0] next_cfg_rdata;
  logic        next_cfg_rdata_valid;

  // A read in the same cycle as a write returns the value before the write.
  // Data is zero whenever no read was taken, so stale words never linger.
  always_comb
  begin
    next_cfg_rdata       = '0;
    next_cfg_rdata_valid = cfg_read;
    if (cfg_read)
    begin
      if (cfg_dword == DWORD_LOW_IDX)
        next_cfg_rdata = {16'h0000,
                          io_window_limit_low[cfg_port], ADDR32_CAP,
                          io_window_base_low[cfg_port], ADDR32_CAP};
      else if (cfg_dword == DWORD_HIGH_IDX)
        next_cfg_rdata = {io_window_limit_high[cfg_port], io_window_base_high[cfg_port]};
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_rdata       <= '0;
      cfg_rdata_valid <= 1'b0;
    end
    else
    begin
      cfg_rdata       <= next_cfg_rdata;
      cfg_rdata_valid <= next_cfg_rdata_valid;
    end
  end

  // ----------------------------------------------------------------
  // Window match per port
  // ----------------------------------------------------------------
  logic [NUM_SEC-1:0] in_window;
  logic [NUM_SEC-1:0] claim;

  // ISA holes are cut per port, each with its own ISA enable bit
  for (genvar g = 0; g < NUM_SEC; g++)
  begin : g_win
    tpiod_window_match #(
      .ADDR_W (ADDR_W)
    ) u_match (
      .base_high  (io_window_base_high[g]),
      .base_nib   (io_window_base_low[g]),
      .limit_high (io_window_limit_high[g]),
      .limit_nib  (io_window_limit_low[g]),
      .isa_enable (isa_enable[g]),
      .addr       (txn_addr),
      .in_window  (in_window[g]),
      .claim      (claim[g])
    );
  end

  // ----------------------------------------------------------------
  // Routing decision
  // ----------------------------------------------------------------
  logic              next_route_valid;
  logic [2:0]        next_route_dest;
  logic              next_route_ignored;
  logic [ADDR_W-1:0] next_route_addr;

  // Decoding uses the window registers as they stand, so a write reaches the
  // decision one cycle later; software must keep the buses idle meanwhile.
  // Port one wins a primary access claimed by both windows.
  // A cross-port hit does not consult the far port's I/O enable.
  always_comb
  begin
    next_route_valid   = txn_valid;
    next_route_dest    = DEST_NONE;
    next_route_addr    = txn_addr;
    case (txn_origin)
      TPIOD_FROM_PRIMARY:
      begin
        if (txn_is_io && io_enable[0] && claim[0])
          next_route_dest = DEST_SEC_ONE;
        else if (txn_is_io && io_enable[1] && claim[1])
          next_route_dest = DEST_SEC_TWO;
      end
      TPIOD_FROM_SEC_ONE:
      begin
        if (!master_enable[0])
          next_route_dest = DEST_NONE;
        else if (!txn_is_io)
          next_route_dest = DEST_PRIMARY;
        else if (claim[0])
          next_route_dest = DEST_NONE;
        else if (claim[1])
          next_route_dest = DEST_SEC_TWO;
        else
          next_route_dest = DEST_PRIMARY;
      end
      TPIOD_FROM_SEC_TWO:
      begin
        if (!master_enable[1])
          next_route_dest = DEST_NONE;
        else if (!txn_is_io)
          next_route_dest = DEST_PRIMARY;
        else if (claim[1])
          next_route_dest = DEST_NONE;
        else if (claim[0])
          next_route_dest = DEST_SEC_ONE;
        else
          next_route_dest = DEST_PRIMARY;
      end
      default:
        next_route_dest = DEST_NONE;
    endcase
    next_route_ignored = txn_valid && (next_route_dest == DEST_NONE);
    if (!txn_valid)
      next_route_dest = DEST_NONE;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      route_valid   <= 1'b0;
      route_dest    <= DEST_NONE;
      route_ignored <= 1'b0;
      route_addr    <= '0;
    end
    else
    begin
      route_valid   <= next_route_valid;
      route_dest    <= next_route_dest;
      route_ignored <= next_route_ignored;
      route_addr    <= next_route_addr;
    end
  end

endmodule

/* tb/tpiod_decoder_monitor.sv */
// Concurrent checks on the decoder's routing and config read ports
`timescale 1ns/1ps

module tpiod_decoder_monitor
#(
  parameter int ADDR_W  = 32,
  parameter int NUM_SEC = 2
)
(
  input wire logic                     ref_clk,
  input wire logic                     reset_n,
  input wire logic [NUM_SEC-1:0]       io_enable,
  input wire logic [NUM_SEC-1:0]       master_enable,
  input wire logic                     cfg_read,
  input wire logic [31:0]              cfg_rdata,
  input wire logic                     cfg_rdata_valid,
  input wire logic                     txn_valid,
  input wire tpiod_pkg::tpiod_origin_t txn_origin,
  input wire logic                     txn_is_io,
  input wire logic [ADDR_W-1:0]        txn_addr,
  input wire logic                     route_valid,
  input wire logic [2:0]               route_dest,
  input wire logic                     route_ignored,
  input wire logic [ADDR_W-1:0]        route_addr
);
  import tpiod_pkg::*;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  // ----------------------------------------------------------------
  // Request shapes
  // ----------------------------------------------------------------
  sequence txn_taken;
    txn_valid;
  endsequence

  sequence prim_io_shut;
    txn_valid && txn_origin == TPIOD_FROM_PRIMARY && txn_is_io && io_enable == '0;
  endsequence

  sequence sec_master_off;
    txn_valid && (txn_origin == TPIOD_FROM_SEC_ONE && !master_enable[0]
                  || txn_origin == TPIOD_FROM_SEC_TWO && !master_enable[1]);
  endsequence

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  answer_time_a: assert property (txn_taken |=> route_valid) else $error("route answer missing");
  idle_quiet_a: assert property (!txn_valid |=> !route_valid) else $error("route answer unasked");
  addr_pass_a: assert property (txn_taken |=> route_addr == $past(txn_addr)) else $error("address changed");
  ignore_flag_a: assert property (route_valid |-> route_ignored == (route_dest == DEST_NONE))
    else $error("ignore flag disagrees with destination");
  io_shut_a: assert property (prim_io_shut |=> route_ignored) else $error("primary I/O passed while off");
  master_off_a: assert property (sec_master_off |=> route_ignored) else $error("secondary passed while off");
  prim_down_a: assert property (txn_taken ##0 txn_origin == TPIOD_FROM_PRIMARY |=> route_dest != DEST_PRIMARY)
    else $error("primary request sent back up");
  own_port_a: assert property (txn_valid && txn_origin == TPIOD_FROM_SEC_ONE |=> (route_dest & DEST_SEC_ONE) == 3'h0)
    else $error("port one request sent to itself");
  mem_up_a: assert property (txn_valid && txn_origin == TPIOD_FROM_SEC_TWO && !txn_is_io && master_enable[1]
    |=> route_dest == DEST_PRIMARY) else $error("memory not sent up");
  dest_onehot_a: assert property (route_valid |-> $onehot0(route_dest)) else $error("several destinations");
  read_answer_a: assert property (cfg_read |=> cfg_rdata_valid) else $error("read answer missing");
  read_stand_a: assert property (!cfg_read |=> !cfg_rdata_valid && cfg_rdata == 32'h0) else $error("read data lingers");
  own_two_a: assert property (txn_valid && txn_origin == TPIOD_FROM_SEC_TWO |=> (route_dest & DEST_SEC_TWO) == 3'h0)
    else $error("port two request sent to itself");
endmodule

bind tpiod_decoder tpiod_decoder_monitor #(.ADDR_W(ADDR_W), .NUM_SEC(NUM_SEC)) u_monitor (.*);

/* tb/tpiod_bus_agent.sv */
// Initiator model for transactions arriving from the three buses
`timescale 1ns/1ps

module tpiod_bus_agent
#(
  parameter int ADDR_W = 32
)
(
  input  wire logic                  ref_clk,
  output logic                       txn_valid,
  output tpiod_pkg::tpiod_origin_t   txn_origin,
  output logic                       txn_is_io,
  output logic [ADDR_W-1:0]          txn_addr
);
  import tpiod_pkg::*;

  initial
  begin
    txn_valid = 1'b0;
    txn_origin = TPIOD_FROM_PRIMARY;
    txn_is_io = 1'b0;
    txn_addr = '0;
  end

  // One request per call, optionally after idle cycles; lines scrambled once released
  task automatic send(input tpiod_origin_t o, input logic io, input logic [ADDR_W-1:0] a, input int gap);
    repeat (gap) @(posedge ref_clk);
    @(posedge ref_clk);
    #1;
    txn_valid = 1'b1;
    txn_origin = o;
    txn_is_io = io;
    txn_addr = a;
    @(posedge ref_clk);
    #1;
    txn_valid = 1'b0;
    txn_is_io = ~io;
    txn_addr = ~a;
  endtask
endmodule

/* tb/test_three_port_io_address_decoder.sv */
// Self-checking bench for the three-port I/O address decoder
`timescale 1ns/1ps

module test_three_port_io_address_decoder;
  import tpiod_pkg::*;

  localparam tpiod_origin_t OP = TPIOD_FROM_PRIMARY;
  localparam tpiod_origin_t O1 = TPIOD_FROM_SEC_ONE;
  localparam tpiod_origin_t O2 = TPIOD_FROM_SEC_TWO;
  localparam logic [2:0] DN = DEST_NONE;
  localparam logic [2:0] DP = DEST_PRIMARY;
  localparam logic [2:0] D1 = DEST_SEC_ONE;
  localparam logic [2:0] D2 = DEST_SEC_TWO;

  logic ref_clk = 1'b0;
  logic reset_n, prim_bus_reset, cfg_write, cfg_read, cfg_port, cfg_rdata_valid;
  logic [1:0] io_enable, master_enable, isa_enable;
  logic [7:0] cfg_addr;
  logic [3:0] cfg_byte_en;
  logic [31:0] cfg_wdata, cfg_rdata, txn_addr, route_addr;
  logic txn_valid, txn_is_io, route_valid, route_ignored;
  logic [2:0] route_dest;
  tpiod_origin_t txn_origin;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;

  tpiod_decoder u_dut (.*);
  tpiod_bus_agent u_agent (.*);

  always #2.5 ref_clk = ~ref_clk;

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      errors++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    if (errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cfg_wr(input logic p, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    #1;
    cfg_write = 1'b1;
    cfg_port = p;
    cfg_addr = a;
    cfg_wdata = d;
    @(posedge ref_clk);
    #1;
    cfg_write = 1'b0;
    cfg_wdata = ~d;
  endtask

  task automatic cfg_rd(input logic p, input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    #1;
    cfg_read = 1'b1;
    cfg_port = p;
    cfg_addr = a;
    @(posedge ref_clk);
    #1;
    cfg_read = 1'b0;
    chk("cfg_rdata_valid", 32'h1, {31'h0, cfg_rdata_valid});
    chk("cfg_rdata", exp, cfg_rdata);
  endtask

  task automatic rt(input tpiod_origin_t o, input logic io, input logic [31:0] a, input logic [2:0] d);
    u_agent.send(o, io, a, 0);
    chk("route", {27'h0, 1'b1, d == DN, d}, {27'h0, route_valid, route_ignored, route_dest});
    chk("route_addr", a, route_addr);
  endtask

  task automatic enables(input logic [1:0] v);
    io_enable = v;
    master_enable = v;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    cfg_rd(0, 8'h1c, 32'h0000_0101);
    cfg_rd(1, 8'h30, 32'h0000_0000);
    io_enable = 2'b01;
    rt(OP, 1, 32'h0000_0fff, D1);
    rt(OP, 1, 32'h0000_1000, DN);
  endtask

  task automatic t_regs();
    cfg_wr(0, 8'h1c, 32'hffff_ffff);
    cfg_rd(0, 8'h1c, 32'h0000_f1f1);
    cfg_wr(1, 8'h30, 32'h1234_5678);
    cfg_rd(1, 8'h30, 32'h1234_5678);
    cfg_byte_en = 4'h2;
    cfg_wr(1, 8'h30, 32'h0000_ab00);
    cfg_rd(1, 8'h30, 32'h1234_ab78);
    cfg_byte_en = 4'h1;
    cfg_wr(0, 8'h1c, 32'h0000_0000);
    cfg_rd(0, 8'h1c, 32'h0000_f101);
    cfg_byte_en = 4'hf;
    cfg_rd(0, 8'h30, 32'h0000_0000);
    cfg_wr(0, 8'h40, 32'hffff_ffff);
    cfg_rd(0, 8'h40, 32'h0000_0000);
  endtask

  task automatic t_route();
    enables(2'b00);
    cfg_wr(0, 8'h1c, 32'h0000_3121);
    cfg_wr(0, 8'h30, 32'h0001_0001);
    cfg_wr(1, 8'h1c, 32'h0000_0101);
    cfg_wr(1, 8'h30, 32'h0002_0002);
    enables(2'b11);
    rt(OP, 1, 32'h0001_1fff, DN);
    rt(OP, 1, 32'h0001_2000, D1);
    rt(OP, 1, 32'h0001_3fff, D1);
    rt(OP, 1, 32'h0001_4000, DN);
    rt(OP, 1, 32'h0002_0abc, D2);
    rt(O1, 1, 32'h0001_2000, DN);
    rt(O1, 1, 32'h0002_0000, D2);
    rt(O1, 1, 32'h0005_0000, DP);
    rt(O2, 1, 32'h0001_3000, D1);
    rt(O2, 1, 32'h0002_0fff, DN);
    rt(O2, 0, 32'h0001_3000, DP);
  endtask

  task automatic t_enables();
    io_enable = 2'b00;
    rt(OP, 1, 32'h0001_2000, DN);
    io_enable = 2'b11;
    master_enable = 2'b10;
    rt(O1, 1, 32'h0005_0000, DN);
    rt(O1, 0, 32'h0005_0000, DN);
    rt(O2, 1, 32'h0005_0000, DP);
    rt(tpiod_origin_t'(2'h3), 1, 32'h0001_2000, DN);
  endtask

  task automatic t_off();
    enables(2'b00);
    cfg_wr(0, 8'h1c, 32'h0000_3151);
    enables(2'b11);
    rt(OP, 1, 32'h0001_3000, DN);
    rt(O1, 1, 32'h0001_3000, DP);
    rt(O2, 1, 32'h0001_3000, DP);
  endtask

  task automatic t_isa();
    enables(2'b00);
    cfg_wr(0, 8'h1c, 32'h0000_f101);
    cfg_wr(0, 8'h30, 32'h0000_0000);
    isa_enable = 2'b11;
    enables(2'b11);
    rt(OP, 1, 32'h0000_0400, D1);
    rt(OP, 1, 32'h0000_0500, DN);
    rt(OP, 1, 32'h0000_ffff, DN);
    rt(OP, 1, 32'h0000_fcff, D1);
    rt(OP, 1, 32'h0002_0500, D2);
    rt(O1, 1, 32'h0000_0500, DP);
    rt(O1, 1, 32'h0000_0400, DN);
    master_enable = 2'b10;
    rt(O1, 1, 32'h0000_0500, DN);
    master_enable = 2'b11;
    isa_enable = 2'b00;
    rt(OP, 1, 32'h0000_0500, D1);
  endtask

  task automatic t_busrst();
    @(posedge ref_clk);
    #1;
    prim_bus_reset = 1'b1;
    cfg_wr(0, 8'h1c, 32'hffff_ffff);
    prim_bus_reset = 1'b0;
    cfg_rd(0, 8'h1c, 32'h0000_0101);
    cfg_rd(1, 8'h30, 32'h0000_0000);
    rt(OP, 1, 32'h0000_0fff, D1);
  endtask

  initial
  begin
    reset_n = 1'b0;
    prim_bus_reset = 1'b0;
    enables(2'b00);
    isa_enable = 2'b00;
    cfg_write = 1'b0;
    cfg_read = 1'b0;
    cfg_port = 1'b0;
    cfg_addr = 8'h00;
    cfg_byte_en = 4'hf;
    cfg_wdata = 32'h0;
    repeat (2) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    t_reset();
    t_regs();
    t_route();
    t_enables();
    t_off();
    t_isa();
    t_busrst();
    end_of_test();
  end
endmodule
